// File: rtl/cfs_pkg.sv
// package for the instruction fetch sequencer: widths, offsets, encodings
// assumes a single 25 MHz system clock and a 16-bit wide program memory
package cfs_pkg;
	// program memory geometry: 32K words max, 13-bit page offset plus bank
	localparam int PC_W = 15;
	localparam int PAGE_W = 13;
	localparam int BANK_W = 2;
	localparam int WORD_W = 16;
	localparam int DATA_W = 8;
	localparam int STACK_DEPTH = 8;
	localparam int SP_W = 4;
	// register offsets on the plain register port
	localparam logic [3:0] REG_PC_LOW = 4'h0;
	localparam logic [3:0] REG_BANK = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_ACC = 4'h3;
	localparam logic [3:0] REG_INT_CTRL = 4'h4;
	// reset values
	localparam logic [PC_W-1:0] RESET_VECTOR = 15'h0000;
	localparam logic [PC_W-1:0] INT_VECTOR = 15'h0004;
	localparam logic [SP_W-1:0] SP_RESET = 4'h0;
	// status flag bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_AC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	// instruction word fields: [15:12] class, [11:8] sub-op, [7:0] operand
	localparam int OP_HI = 15;
	localparam int OP_LO = 12;
	localparam int SUB_HI = 11;
	localparam int SUB_LO = 8;
	// instruction classes
	typedef enum logic [3:0] {
		CFS_OP_NOP = 4'h0,
		CFS_OP_ALU = 4'h1,
		CFS_OP_LONG = 4'h2,
		CFS_OP_JUMP = 4'h3,
		CFS_OP_CALL = 4'h4,
		CFS_OP_RET = 4'h5,
		CFS_OP_INTERRUPT_RETURN_OP = 4'h6,
		CFS_OP_SKIP = 4'h7
	} cfs_op_t;
	// alu operation select
	typedef enum logic [3:0] {
		CFS_ALU_ADD = 4'h0,
		CFS_ALU_ADC = 4'h1,
		CFS_ALU_SUB = 4'h2,
		CFS_ALU_SBC = 4'h3,
		CFS_ALU_DAA = 4'h4,
		CFS_ALU_AND = 4'h5,
		CFS_ALU_OR = 4'h6,
		CFS_ALU_XOR = 4'h7,
		CFS_ALU_CPL = 4'h8,
		CFS_ALU_RR = 4'h9,
		CFS_ALU_RRC = 4'ha,
		CFS_ALU_RL = 4'hb,
		CFS_ALU_RLC = 4'hc,
		CFS_ALU_INC = 4'hd,
		CFS_ALU_DEC = 4'he,
		CFS_ALU_MOV = 4'hf
	} cfs_alu_t;
	// phase of the instruction cycle, one system clock each
	typedef enum logic [1:0] {
		CFS_T1 = 2'b00,
		CFS_T2 = 2'b01,
		CFS_T3 = 2'b10,
		CFS_T4 = 2'b11
	} cfs_phase_t;
	// program memory request toward the flash
	typedef struct packed {
		logic rd;
		logic [PC_W-1:0] addr;
	} cfs_fetch_t;
endpackage : cfs_pkg

// File: rtl/cfs_sequencer.sv
// instruction fetch sequencer: four-phase cycle, pc, stack and 8-bit alu
// assumes a flash returning the word in the same clock as the fetch request
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/10ps

// Notes on behaviour
// - four phases derived from the system clock make one instruction cycle.
// - pc advances at start of first phase while new word is fetched.
// - phases two to four decode and execute the word fetched in the first phase.
// - any pc-changing instruction costs one extra instruction cycle.
// - standard words take one cycle, extended words two.
// - pc advances by one per instruction except jump, call, return or interrupt targets and pc low writes.
// - jump, call, interrupt and reset load target address into pc.
// - satisfied skip discards fetched word and runs a dummy cycle.
// - pc low byte is readable and writable by software.
// - pc low write jumps within current 256-word page, adds dummy cycle.
// - bank pointer bits extend the program memory address.
// - bit 0 selects two banks, bits 0 and 1 select four banks.
// - memory is 16 bits wide; pc spans up to 32K words.
// - stack holds only pc values; contents and pointer are hidden.
// - call or interrupt pushes pc; return ops pop it back.
// - after reset the stack pointer points to top of stack.
// - with stack full, interrupt flag is kept but acknowledge waits for pop.
// - call with full stack proceeds and the oldest entry is lost.
// - an 8-bit alu handles operations through the accumulator.
// - alu gives add, sub, carry forms, daa, logic, rotates, inc, dec.
// - alu result goes to destination and status flags update.
// - after reset the pc is zero, the reset vector.
module cfs_sequencer (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output cfs_pkg::cfs_fetch_t fetch_req,
	input wire logic [15:0] fetch_word,
	input wire logic int_pin,
	output logic [1:0] phase_out,
	output logic int_ack
);
	// phase counter and derived phase strobes
	cfs_pkg::cfs_phase_t phase_reg;
	logic [14:0] pc_reg;
	logic [14:0] pc_next;
	logic [15:0] ir_reg;
	logic ir_valid_reg;
	logic dummy_reg;
	logic long_half_reg;
	logic [1:0] bank_reg;
	logic [7:0] acc_reg;
	logic [3:0] flags_reg;
	logic int_en_reg;
	logic int_flag_reg;
	logic [14:0] stack_mem [0:cfs_pkg::STACK_DEPTH-1];
	logic [3:0] sp_reg;
	logic int_s1_reg;
	logic int_s2_reg;

	wire logic t1 = (phase_reg == cfs_pkg::CFS_T1);
	wire logic t4 = (phase_reg == cfs_pkg::CFS_T4);

	// decode of the word fetched in this cycle's first phase
	wire logic [3:0] op_w = ir_reg[cfs_pkg::OP_HI:cfs_pkg::OP_LO];
	wire logic [3:0] sub_w = ir_reg[cfs_pkg::SUB_HI:cfs_pkg::SUB_LO];
	wire logic [7:0] imm_w = ir_reg[7:0];
	wire logic live_w = ir_valid_reg && !dummy_reg;
	wire logic is_alu = live_w && op_w == cfs_pkg::CFS_OP_ALU;
	wire logic is_long = live_w && op_w == cfs_pkg::CFS_OP_LONG;
	wire logic is_jump = live_w && op_w == cfs_pkg::CFS_OP_JUMP;
	wire logic is_call = live_w && op_w == cfs_pkg::CFS_OP_CALL;
	wire logic is_ret = live_w && (op_w == cfs_pkg::CFS_OP_RET
		|| op_w == cfs_pkg::CFS_OP_INTERRUPT_RETURN_OP);
	wire logic is_skip = live_w && op_w == cfs_pkg::CFS_OP_SKIP;
	wire logic pcl_wr = reg_wr && reg_addr == cfs_pkg::REG_PC_LOW;
	wire logic bank_wr = reg_wr && reg_addr == cfs_pkg::REG_BANK;
	// a low byte write waits for a fourth phase that can take it
	logic pcl_pend_reg;
	logic [7:0] pcl_val_reg;
	wire logic pcl_go = pcl_wr || pcl_pend_reg;
	wire logic [7:0] pcl_val = pcl_wr ? reg_wdata : pcl_val_reg;

	// stack state
	wire logic stack_full = (sp_reg == 4'(cfs_pkg::STACK_DEPTH));
	wire logic stack_empty = (sp_reg == cfs_pkg::SP_RESET);
	wire logic [2:0] push_slot = 3'(sp_reg);
	wire logic [2:0] pop_slot = 3'(sp_reg - 4'h1);
	// pending low byte write lands unless a branch owns the slot
	wire logic pcl_lands = pcl_go && !is_jump && !is_call
		&& !(is_ret && !stack_empty);

	// alu: accumulator op immediate, carry in from status
	logic [8:0] alu_res;
	logic [7:0] daa_adj;
	wire logic cin = flags_reg[cfs_pkg::FLAG_C];
	wire logic [7:0] opb = imm_w;
	wire cfs_pkg::cfs_alu_t alu_sel = cfs_pkg::cfs_alu_t'(sub_w);
	always_comb begin
		daa_adj = 8'h00;
		if (acc_reg[3:0] > 4'h9 || flags_reg[cfs_pkg::FLAG_AC])
			daa_adj[3:0] = 4'h6;
		if (acc_reg[7:4] > 4'h9 || cin)
			daa_adj[7:4] = 4'h6;
		case (alu_sel)
			cfs_pkg::CFS_ALU_ADD: alu_res = {1'b0, acc_reg} + {1'b0, opb};
			cfs_pkg::CFS_ALU_ADC: alu_res = {1'b0, acc_reg} + {1'b0, opb}
				+ {8'h00, cin};
			cfs_pkg::CFS_ALU_SUB: alu_res = {1'b0, acc_reg} - {1'b0, opb};
			cfs_pkg::CFS_ALU_SBC: alu_res = {1'b0, acc_reg} - {1'b0, opb}
				- {8'h00, !cin};
			cfs_pkg::CFS_ALU_DAA: alu_res = {1'b0, acc_reg} + {1'b0, daa_adj};
			cfs_pkg::CFS_ALU_AND: alu_res = {cin, acc_reg & opb};
			cfs_pkg::CFS_ALU_OR: alu_res = {cin, acc_reg | opb};
			cfs_pkg::CFS_ALU_XOR: alu_res = {cin, acc_reg ^ opb};
			cfs_pkg::CFS_ALU_CPL: alu_res = {cin, ~acc_reg};
			cfs_pkg::CFS_ALU_RR: alu_res = {cin, acc_reg[0], acc_reg[7:1]};
			cfs_pkg::CFS_ALU_RRC: alu_res = {acc_reg[0], cin, acc_reg[7:1]};
			cfs_pkg::CFS_ALU_RL: alu_res = {cin, acc_reg[6:0], acc_reg[7]};
			cfs_pkg::CFS_ALU_RLC: alu_res = {acc_reg[7], acc_reg[6:0], cin};
			cfs_pkg::CFS_ALU_INC: alu_res = {cin, acc_reg + 8'h01};
			cfs_pkg::CFS_ALU_DEC: alu_res = {cin, acc_reg - 8'h01};
			default: alu_res = {cin, opb};
		endcase
	end

	// carry on add is carry out; on subtract it is no-borrow
	wire logic is_sub_op = alu_sel == cfs_pkg::CFS_ALU_SUB
		|| alu_sel == cfs_pkg::CFS_ALU_SBC;
	wire logic c_out = is_sub_op ? !alu_res[8] : alu_res[8];
	wire logic ac_out = (acc_reg[3:0] + opb[3:0]) > 5'h0f;
	wire logic ov_out = (acc_reg[7] == opb[7]) && (alu_res[7] != acc_reg[7]);
	// skip when the alu result is zero (sub-op applied to accumulator and operand)
	wire logic skip_hit = is_skip && (alu_res[7:0] == 8'h00);
	// a long word takes a second cycle for its operand word
	wire logic long_first = is_long && !long_half_reg;
	// any pc change costs a flushed slot
	wire logic redirect = is_jump || is_call || is_ret || pcl_go;

	// interrupt acknowledge waits while the stack is full
	wire logic take_int = int_flag_reg && int_en_reg && !stack_full
		&& !redirect && !long_first && !skip_hit;

	// next program counter at the end of the cycle
	always_comb begin
		pc_next = pc_reg + 15'h0001;
		if (take_int)
			pc_next = cfs_pkg::INT_VECTOR;
		else if (is_jump || is_call)
			pc_next = {bank_reg, ir_reg[12:0]};
		else if (is_ret && !stack_empty)
			pc_next = stack_mem[pop_slot];
		else if (pcl_go)
			pc_next = {pc_reg[14:8], pcl_val};
	end

	// hold a low byte write until the slot that can take it
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pcl_pend_reg <= 1'b0;
			pcl_val_reg <= 8'h00;
		end else begin
			if (t4 && pcl_lands)
				pcl_pend_reg <= 1'b0;
			else if (pcl_wr)
				pcl_pend_reg <= 1'b1;
			if (pcl_wr)
				pcl_val_reg <= reg_wdata;
		end
	end

	// input pin synchroniser
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			int_s1_reg <= 1'b0;
			int_s2_reg <= 1'b0;
		end else begin
			int_s1_reg <= int_pin;
			int_s2_reg <= int_s1_reg;
		end
	end

	// phase divider: one clock per phase
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			phase_reg <= cfs_pkg::CFS_T1;
		else
			phase_reg <= cfs_pkg::cfs_phase_t'(phase_reg + 2'b01);
	end

	// pc, fetch and pipeline slot
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pc_reg <= cfs_pkg::RESET_VECTOR;
			ir_reg <= 16'h0000;
			ir_valid_reg <= 1'b0;
			dummy_reg <= 1'b0;
			long_half_reg <= 1'b0;
			fetch_req <= '0;
		end else begin
			fetch_req.rd <= t4;
			if (t4) begin
				fetch_req.addr <= pc_reg;
				pc_reg <= pc_next;
			end
			if (t1) begin
				ir_reg <= fetch_word;
				ir_valid_reg <= 1'b1;
			end
			if (t4) begin
				dummy_reg <= redirect || skip_hit || take_int;
				long_half_reg <= long_first;
			end
		end
	end

	// return stack, pointer counts filled slots from the top
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			sp_reg <= cfs_pkg::SP_RESET;
		else if (t4 && (is_call || take_int) && !stack_full)
			sp_reg <= sp_reg + 4'h1;
		else if (t4 && is_ret && !stack_empty)
			sp_reg <= sp_reg - 4'h1;
	end

	// stack storage; a full push shifts out the oldest entry
	always_ff @(posedge sys_clk) begin
		if (t4 && (is_call || take_int)) begin
			if (stack_full) begin
				for (int i = 0; i < cfs_pkg::STACK_DEPTH - 1; i++)
					stack_mem[i] <= stack_mem[i+1];
				stack_mem[cfs_pkg::STACK_DEPTH-1] <= pc_reg;
			end else
				stack_mem[push_slot] <= pc_reg;
		end
	end

	// alu result and flags at end of execute
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			acc_reg <= 8'h00;
			flags_reg <= 4'h0;
		end else if (t4 && is_alu) begin
			acc_reg <= alu_res[7:0];
			flags_reg[cfs_pkg::FLAG_C] <= c_out;
			flags_reg[cfs_pkg::FLAG_AC] <= ac_out;
			flags_reg[cfs_pkg::FLAG_Z] <= alu_res[7:0] == 8'h00;
			flags_reg[cfs_pkg::FLAG_OV] <= ov_out;
		end else if (reg_wr && reg_addr == cfs_pkg::REG_ACC)
			acc_reg <= reg_wdata;
		else if (reg_wr && reg_addr == cfs_pkg::REG_STATUS)
			flags_reg <= reg_wdata[3:0];
	end

	// bank pointer, interrupt enable and request flag
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bank_reg <= 2'b00;
			int_en_reg <= 1'b0;
			int_flag_reg <= 1'b0;
			int_ack <= 1'b0;
		end else begin
			if (bank_wr)
				bank_reg <= reg_wdata[1:0];
			if (reg_wr && reg_addr == cfs_pkg::REG_INT_CTRL)
				int_en_reg <= reg_wdata[0];
			// set wins over the acknowledge clear
			if (int_s2_reg)
				int_flag_reg <= 1'b1;
			else if (t4 && take_int)
				int_flag_reg <= 1'b0;
			int_ack <= t4 && take_int;
		end
	end

	// read data one cycle after the read strobe; stack not mapped
	wire logic [7:0] rd_mux =
		reg_addr == cfs_pkg::REG_PC_LOW ? pc_reg[7:0] :
		reg_addr == cfs_pkg::REG_BANK ? {6'h00, bank_reg} :
		reg_addr == cfs_pkg::REG_STATUS ? {4'h0, flags_reg} :
		reg_addr == cfs_pkg::REG_ACC ? acc_reg :
		reg_addr == cfs_pkg::REG_INT_CTRL ?
			{6'h00, int_flag_reg, int_en_reg} : 8'h00;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
			phase_out <= 2'b00;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
			phase_out <= phase_reg;
		end
	end

	// checks: phase divider and fetch timing
	phase_wrap_a: assert property (
		@(posedge sys_clk) disable iff (!nrst) t4 |=> t1)
		else $error("phase did not wrap");
	phase_out_a: assert property (
		@(posedge sys_clk) disable iff (!nrst) 1'b1 |=> phase_out == $past(phase_reg))
		else $error("phase output out of step");
	fetch_t1_a: assert property (
		@(posedge sys_clk) disable iff (!nrst) fetch_req.rd |-> t1)
		else $error("fetch outside first phase");
	fetch_addr_a: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		t4 |=> fetch_req.rd && fetch_req.addr == $past(pc_reg))
		else $error("fetch address not the old pc");
	ir_load_a: assert property (
		@(posedge sys_clk) disable iff (!nrst) t1 |=> ir_reg == $past(fetch_word))
		else $error("fetched word not latched");

	// checks: program counter
	pc_step_a: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(t4 && !take_int && !redirect) |=> pc_reg == $past(pc_reg) + 15'h1)
		else $error("pc did not advance by one");
	reset_pc_a: assert property (
		@(posedge sys_clk) $rose(nrst) |-> pc_reg == cfs_pkg::RESET_VECTOR)
		else $error("pc not at zero");
	jump_target_a: assert property (
		@(posedge sys_clk) disable iff (!nrst) (t4 && (is_jump || is_call))
		|=> pc_reg == $past({bank_reg, ir_reg[12:0]}))
		else $error("branch target not loaded");
	int_vector_a: assert property (
		@(posedge sys_clk) disable iff (!nrst) (t4 && take_int) |=> pc_reg == cfs_pkg::INT_VECTOR)
		else $error("interrupt vector not loaded");
	jump_dummy_a: assert property (
		@(posedge sys_clk) disable iff (!nrst) (t4 && redirect) |=> dummy_reg)
		else $error("branch slot not flushed");
	skip_dummy_a: assert property (
		@(posedge sys_clk) disable iff (!nrst) (t4 && skip_hit) |=> dummy_reg [*4])
		else $error("skip without dummy");
	long_half_a: assert property (
		@(posedge sys_clk) disable iff (!nrst) (t4 && long_first) |=> long_half_reg)
		else $error("long word without second cycle");
	pcl_page_a: assert property (
		@(posedge sys_clk) disable iff (!nrst) (t4 && pcl_lands)
		|=> pc_reg == {$past(pc_reg[14:8]), $past(pcl_val)})
		else $error("pc low write left page");
	pcl_read_a: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(reg_rd && reg_addr == cfs_pkg::REG_PC_LOW) |=> reg_rdata == $past(pc_reg[7:0]))
		else $error("pc low read wrong");
	rdata_idle_a: assert property (
		@(posedge sys_clk) disable iff (!nrst) !reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without strobe");
	bank_sel_a: assert property (
		@(posedge sys_clk) disable iff (!nrst) bank_wr |=> bank_reg == $past(reg_wdata[1:0]))
		else $error("bank bits not taken");

	// checks: return stack and interrupt
	reset_sp_a: assert property (
		@(posedge sys_clk) $rose(nrst) |-> sp_reg == cfs_pkg::SP_RESET)
		else $error("stack pointer not at top");
	push_sp_a: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(t4 && is_call && !stack_full) |=> sp_reg == $past(sp_reg) + 4'h1)
		else $error("call did not push");
	pop_sp_a: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(t4 && is_ret && !stack_empty) |=> sp_reg == $past(sp_reg) - 4'h1)
		else $error("return did not pop");
	sp_bound_a: assert property (
		@(posedge sys_clk) disable iff (!nrst) sp_reg <= 4'(cfs_pkg::STACK_DEPTH))
		else $error("stack pointer past depth");
	full_call_a: assert property (
		@(posedge sys_clk) disable iff (!nrst) (t4 && is_call && stack_full)
		|=> stack_full && stack_mem[cfs_pkg::STACK_DEPTH-1] == $past(pc_reg))
		else $error("full call not kept");
	full_no_ack_a: assert property (
		@(posedge sys_clk) disable iff (!nrst) stack_full |-> !take_int)
		else $error("ack while full");
	ack_room_a: assert property (
		@(posedge sys_clk) disable iff (!nrst) int_ack |-> !$past(stack_full))
		else $error("ack issued with full stack");
	flag_set_a: assert property (
		@(posedge sys_clk) disable iff (!nrst) int_s2_reg |=> int_flag_reg)
		else $error("request flag not recorded");

	// checks: alu
	alu_zero_a: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(t4 && is_alu) |=> flags_reg[cfs_pkg::FLAG_Z] == (acc_reg == 8'h00))
		else $error("zero flag wrong");
	alu_carry_a: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(t4 && is_alu && alu_sel == cfs_pkg::CFS_ALU_ADD)
		|=> flags_reg[cfs_pkg::FLAG_C] == ($past(opb) > ~$past(acc_reg)))
		else $error("add carry wrong");
endmodule : cfs_sequencer

// File: dv/cfs_flash_model.sv
// flash model: 32K words of 16 bits, answers a fetch in the same cycle
// assumes the bench loads mem by hierarchical reference after time zero
`timescale 1ns/10ps
module cfs_flash_model (
	input wire logic sys_clk,
	input wire cfs_pkg::cfs_fetch_t fetch_req,
	output logic [15:0] fetch_word
);
	logic [15:0] mem [0:32767];
	logic [15:0] last_word;
	// idle data lines show the inverse of the last word, never stale data
	assign fetch_word = fetch_req.rd ? mem[fetch_req.addr] : ~last_word;
	// remember the word handed out
	always @(posedge sys_clk) begin
		if (fetch_req.rd)
			last_word <= mem[fetch_req.addr];
	end
	// blank flash reads as no-operation words
	initial begin
		last_word = 16'h0000;
		foreach (mem[i])
			mem[i] = 16'h0000;
	end
endmodule : cfs_flash_model

// File: dv/cfs_sequencer_test.sv
// self-checking bench for the fetch sequencer beside a flash model
// assumes the design package, the sequencer and the flash model
`timescale 1ns/10ps
module cfs_sequencer_test;
	logic sys_clk, nrst, reg_wr, reg_rd, int_pin, int_ack, rd_seen, chk_fetch;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, r;
	logic [15:0] fetch_word, acks;
	logic [1:0] phase_out, last_phase;
	logic [14:0] hit;
	cfs_pkg::cfs_fetch_t fetch_req;
	int miscompares, check_count, since_rst, n;
	logic [15:0] fetch_q[$];
	logic [7:0] read_q[$];

	cfs_sequencer i_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .fetch_req(fetch_req), .fetch_word(fetch_word),
		.int_pin(int_pin), .phase_out(phase_out), .int_ack(int_ack));
	cfs_flash_model i_rom (.sys_clk(sys_clk), .fetch_req(fetch_req),
		.fetch_word(fetch_word));

	// 25 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic check(input string what, input logic [15:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	// one-cycle write strobe, then one idle cycle
	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask : reg_write

	// one-cycle read, expectation noted for the monitor
	task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
		read_q.push_back(exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
	endtask : reg_read

	task automatic do_reset;
		nrst <= 1'b0;
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
	endtask : do_reset

	// monitor: retire the oldest note whenever a result appears
	always @(posedge sys_clk) begin
		if (rd_seen)
			check("read data", {8'h00, reg_rdata}, {8'h00, read_q.pop_front()});
		rd_seen <= reg_rd;
		if (fetch_req.rd && chk_fetch && fetch_q.size() > 0)
			check("fetch addr", {1'b0, fetch_req.addr}, fetch_q.pop_front());
		if (fetch_req.rd)
			hit <= fetch_req.addr;
		if (int_ack)
			acks <= acks + 16'h0001;
		since_rst <= nrst ? since_rst + 1 : 0;
		if (nrst && since_rst > 3)
			check("phase", {14'h0000, phase_out}, {14'h0000, last_phase + 2'b01});
		last_phase <= phase_out;
	end

	// watchdog cuts a hang short
	initial begin
		#200000;
		miscompares++;
		finish_test();
	end

	// main sequence
	initial begin
		nrst = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		int_pin = 1'b0;
		chk_fetch = 1'b1;
		rd_seen = 1'b0;
		since_rst = 0;
		last_phase = 2'b00;
		acks = 16'h0000;
		hit = 15'h0000;
		miscompares = 0;
		check_count = 0;
		n = $urandom(91);
		@(posedge sys_clk);
		// jump, call, return, then a two-word loop copied to every bank
		i_rom.mem[2] = 16'h3040;
		i_rom.mem[15'h1040] = 16'h4080;
		i_rom.mem[15'h0081] = 16'h5000;
		for (int b = 0; b < 4; b++) begin
			i_rom.mem[b * 8192 + 4162] = 16'h3042;
			i_rom.mem[b * 8192 + 4163] = 16'h3042;
		end
		i_rom.mem[15'h7060] = 16'h3060;
		i_rom.mem[15'h7061] = 16'h3060;
		fetch_q = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h1040, 16'h1041,
			16'h0080, 16'h0081, 16'h0082, 16'h1041, 16'h1042, 16'h1043, 16'h1042};
		do_reset();
		repeat (80) @(posedge sys_clk);
		check("fetches left", 16'(fetch_q.size()), 16'h0000);
		chk_fetch = 1'b0;
		// bank pointer read back, unmapped places read zero
		r = {6'h00, 2'($urandom())};
		reg_write(cfs_pkg::REG_BANK, r);
		reg_read(cfs_pkg::REG_BANK, r);
		repeat (4) begin
			reg_addr <= 4'($urandom_range(15, 5));
			@(posedge sys_clk);
			reg_write(reg_addr, 8'($urandom()));
			reg_read(reg_addr, 8'h00);
		end
		// bank bits extend jump targets
		reg_write(cfs_pkg::REG_BANK, 8'h03);
		repeat (40) @(posedge sys_clk);
		check("bank loop", {1'b0, hit[14:1], 1'b0}, 16'h7042);
		// low byte write jumps inside the current page
		reg_write(cfs_pkg::REG_PC_LOW, 8'h60);
		repeat (40) @(posedge sys_clk);
		check("page jump", {1'b0, hit[14:1], 1'b0}, 16'h7060);
		// eight nested calls fill the stack, then an interrupt waits
		i_rom.mem[2] = 16'h4102;
		for (int i = 1; i < 8; i++)
			i_rom.mem[256 + 2 * i] = 16'h4100 + 16'(2 * i + 2);
		i_rom.mem[15'h0110] = 16'h3110;
		i_rom.mem[15'h1110] = 16'h3110;
		do_reset();
		repeat (120) @(posedge sys_clk);
		reg_write(cfs_pkg::REG_INT_CTRL, 8'h01);
		int_pin <= 1'b1;
		acks <= 16'h0000;
		repeat (60) @(posedge sys_clk);
		check("ack held", acks, 16'h0000);
		reg_read(cfs_pkg::REG_INT_CTRL, 8'h03);
		i_rom.mem[15'h1110] = 16'h5000;
		for (n = 0; n < 80 && acks == 16'h0000; n++)
			@(posedge sys_clk);
		int_pin <= 1'b0;
		check("ack after pop", {15'h0000, acks != 16'h0000}, 16'h0001);
		repeat (8) @(posedge sys_clk);
		// alu through the accumulator; a taken skip drops the next word
		i_rom.mem[0] = 16'h1005;
		i_rom.mem[1] = 16'h1203;
		i_rom.mem[2] = 16'h7f00;
		i_rom.mem[3] = 16'h1001;
		i_rom.mem[4] = 16'h10ff;
		i_rom.mem[5] = 16'h3005;
		i_rom.mem[15'h1005] = 16'h3005;
		do_reset();
		repeat (60) @(posedge sys_clk);
		reg_read(cfs_pkg::REG_ACC, 8'h01);
		reg_read(cfs_pkg::REG_STATUS, 8'h03);
		repeat (4) @(posedge sys_clk);
		finish_test();
	end
endmodule : cfs_sequencer_test
